// ---- hdl/rpn_defines.svh ----
// Key codes, field limits, letter table and reset values for the stack unit
`ifndef RPN_DEFINES_SVH
`define RPN_DEFINES_SVH

`define KEY_POINT 5'h0a
`define KEY_ENTER 5'h0b
`define KEY_SIGN_TOGGLE 5'h0c
`define KEY_EXP_ENTRY 5'h0d
`define KEY_CLEAR_X_POP 5'h0e
`define KEY_ROLL 5'h0f
`define KEY_RUN 5'h10
`define KEY_STEP 5'h11
`define KEY_STOP 5'h12
`define KEY_PAUSE 5'h13
`define KEY_ADD 5'h14
`define KEY_DIV 5'h17
`define KEY_SGN 5'h1c

`define CHAR_POINT 4'ha
`define ENT_MAX 4'd12
`define EXP_MAX 10'sd99
`define EXP_MIN (-10'sd99)
`define LET_RANGE 12
`define LET_BIAS 4
`define MANT_ONE 16'h1000
`define READY_RST 1'b1

`define LET_0 8'h70
`define LET_1 8'h6e
`define LET_2 8'h75
`define LET_3 8'h6d
`define LET_4 8'h20
`define LET_5 8'h4b
`define LET_6 8'h4d
`define LET_7 8'h47
`define LET_8 8'h54

`endif

// ---- hdl/rpn_pkg.sv ----
// Types shared by the stack and entry unit
package rpn_pkg;
  typedef struct packed {
    logic neg;
    logic [15:0] mant;
    logic signed [9:0] exp;
  } value_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MANT = 2'b01,
    ST_EXP = 2'b11,
    ST_BUSY = 2'b10
  } st_t;

  typedef struct packed {
    logic [47:0] chars;
    logic [3:0] cnt;
    logic pnt;
    logic mneg;
    logic [3:0] d1;
    logic [3:0] d0;
    logic eneg;
  } ent_t;

  typedef struct packed {
    logic left;
    logic [47:0] chars;
    logic [3:0] cnt;
    logic sign;
    logic [15:0] mant;
    logic [1:0] point;
    logic [7:0] exp_bcd;
    logic exp_neg;
    logic letter_on;
    logic ovf;
    logic unf;
  } disp_t;
endpackage : rpn_pkg

// ---- hdl/exp_letter_rom.sv ----
// Engineering prefix letter table with registered read data
`timescale 1ns/1ps
`include "rpn_defines.svh"
module exp_letter_rom (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Read port
  input wire logic [3:0] addr,
  output logic [7:0] data_r
);
  logic [7:0] data_nxt;

  always_comb begin
    case (addr)
      4'h0: data_nxt = `LET_0;
      4'h1: data_nxt = `LET_1;
      4'h2: data_nxt = `LET_2;
      4'h3: data_nxt = `LET_3;
      4'h5: data_nxt = `LET_5;
      4'h6: data_nxt = `LET_6;
      4'h7: data_nxt = `LET_7;
      4'h8: data_nxt = `LET_8;
      default: data_nxt = `LET_4;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r <= 8'h00;
    end else begin
      data_r <= data_nxt;
    end
  end
endmodule : exp_letter_rom

// ---- hdl/rpn_stack_entry_unit.sv ----
// Keystroke stack, numeric entry parser and X display formatter
`timescale 1ns/1ps
`include "rpn_defines.svh"
module rpn_stack_entry_unit
  import rpn_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Keypad commands
  input wire logic key_valid,
  input wire logic [4:0] key_code,
  output logic key_ready,
  output logic warn,
  // Arithmetic unit
  output logic fn_req,
  output logic [4:0] fn_code,
  output value_t fn_op_a,
  output value_t fn_op_b,
  input wire logic fn_done,
  input wire value_t fn_result,
  // Stack top
  output value_t x_value,
  // X display field
  output logic disp_left_align,
  output logic [47:0] disp_chars,
  output logic [3:0] disp_char_cnt,
  output logic disp_sign,
  output logic [15:0] disp_mant,
  output logic [1:0] disp_point,
  output logic [7:0] disp_exp_bcd,
  output logic disp_exp_neg,
  output logic disp_letter_on,
  output logic [7:0] disp_letter,
  output logic disp_overflow,
  output logic disp_underflow
);
  st_t st_r, st_nxt;
  value_t stk_r [5];
  value_t stk_nxt [5];
  ent_t ent_r, ent_nxt;
  logic ready_r, ready_nxt;
  logic warn_r, warn_nxt;
  logic req_r, req_nxt;
  logic [4:0] code_r, code_nxt;
  value_t op_a_r, op_a_nxt, op_b_r, op_b_nxt;
  disp_t dsp_r, dsp_nxt;
  logic [3:0] let_addr;
  value_t conv, xe;
  logic take, k_dig, k_fn, k_two;

  // Entry buffer holds one character per nibble, first keyed in the low nibble
  function automatic value_t parse_entry(input ent_t en);
    value_t v;
    int nint;
    int p;
    int first;
    int nsig;
    int ex;
    logic pt;
    logic found;
    logic [15:0] m;
    nint = 0;
    pt = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (i < en.cnt && en.chars[4*i +: 4] == `CHAR_POINT) pt = 1'b1;
      else if (i < en.cnt && !pt) nint++;
    end
    p = nint - 1;
    first = 0;
    nsig = 0;
    found = 1'b0;
    m = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      if (i < en.cnt && en.chars[4*i +: 4] != `CHAR_POINT) begin
        if (!found && en.chars[4*i +: 4] != 4'h0) begin
          found = 1'b1;
          first = p;
        end
        if (found && nsig < 4) begin
          m = {m[11:0], en.chars[4*i +: 4]};
          nsig++;
        end
        p--;
      end
    end
    // Digits past the fourth are truncated, not rounded
    for (int i = 0; i < 4; i++) begin
      if (nsig < 4) begin
        m = {m[11:0], 4'h0};
        nsig++;
      end
    end
    ex = 10 * int'(en.d1) + int'(en.d0);
    if (en.eneg) ex = -ex;
    v.neg = en.mneg;
    v.mant = m;
    v.exp = found ? 10'(first + ex) : 10'sh000;
    return v;
  endfunction : parse_entry

  assign take = key_valid && ready_r;
  assign k_dig = key_code < `KEY_POINT;
  assign k_fn = key_code >= `KEY_ADD && key_code <= `KEY_SGN;
  assign k_two = key_code >= `KEY_ADD && key_code <= `KEY_DIV;

  always_comb begin
    logic push;
    push = 1'b0;
    st_nxt = st_r;
    stk_nxt = stk_r;
    ent_nxt = ent_r;
    warn_nxt = 1'b0;
    req_nxt = 1'b0;
    code_nxt = code_r;
    op_a_nxt = op_a_r;
    op_b_nxt = op_b_r;
    conv = parse_entry(ent_r);
    xe = (st_r == ST_IDLE) ? stk_r[0] : conv;
    case (st_r)
      ST_BUSY: begin
        if (fn_done) begin
          stk_nxt[0] = fn_result;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        if (!take) begin
          st_nxt = st_r;
        end else if (k_dig || key_code == `KEY_POINT) begin
          if (st_r == ST_IDLE) begin
            push = 1'b1;
            ent_nxt = '0;
            ent_nxt.chars[3:0] = key_code[3:0];
            ent_nxt.cnt = 4'd1;
            ent_nxt.pnt = !k_dig;
            st_nxt = ST_MANT;
          end else if (st_r == ST_EXP) begin
            if (k_dig) begin
              ent_nxt.d1 = ent_r.d0;
              ent_nxt.d0 = key_code[3:0];
            end else begin
              warn_nxt = 1'b1;
            end
          end else if (ent_r.cnt == `ENT_MAX || (!k_dig && ent_r.pnt)) begin
            warn_nxt = 1'b1;
          end else begin
            ent_nxt.chars[{ent_r.cnt, 2'b00} +: 4] = key_code[3:0];
            ent_nxt.cnt = ent_r.cnt + 4'd1;
            ent_nxt.pnt = ent_r.pnt || !k_dig;
          end
        end else if (key_code == `KEY_SIGN_TOGGLE) begin
          if (st_r == ST_EXP) ent_nxt.eneg = !ent_r.eneg;
          else if (st_r == ST_MANT) ent_nxt.mneg = !ent_r.mneg;
          else stk_nxt[0].neg = !stk_r[0].neg;
        end else if (key_code == `KEY_EXP_ENTRY) begin
          if (st_r == ST_EXP) begin
            warn_nxt = 1'b1;
          end else begin
            if (st_r == ST_IDLE) begin
              push = 1'b1;
              ent_nxt = '0;
              ent_nxt.chars[3:0] = 4'h1;
              ent_nxt.cnt = 4'd1;
            end
            ent_nxt.d1 = 4'h0;
            ent_nxt.d0 = 4'h0;
            ent_nxt.eneg = 1'b0;
            st_nxt = ST_EXP;
          end
        end else if (key_code >= `KEY_RUN && key_code <= `KEY_PAUSE) begin
          st_nxt = st_r;
        end else begin
          // Any other key closes entry first, so X below is the parsed value
          stk_nxt[0] = xe;
          st_nxt = ST_IDLE;
          if (key_code == `KEY_ENTER && st_r == ST_IDLE) begin
            push = 1'b1;
          end else if (key_code == `KEY_CLEAR_X_POP) begin
            for (int i = 0; i < 4; i++) stk_nxt[i] = stk_r[i+1];
          end else if (key_code == `KEY_ROLL) begin
            for (int i = 0; i < 4; i++) stk_nxt[i] = stk_r[i+1];
            stk_nxt[4] = xe;
          end else if (k_fn) begin
            req_nxt = 1'b1;
            code_nxt = key_code;
            op_b_nxt = xe;
            op_a_nxt = k_two ? stk_r[1] : xe;
            if (k_two) begin
              for (int i = 1; i < 4; i++) stk_nxt[i] = stk_r[i+1];
            end
            st_nxt = ST_BUSY;
          end
        end
      end
    endcase
    if (push) begin
      for (int i = 1; i < 5; i++) stk_nxt[i] = stk_r[i-1];
    end
    ready_nxt = st_nxt != ST_BUSY;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      stk_r <= '{default: '0};
      ent_r <= '0;
      ready_r <= `READY_RST;
      warn_r <= 1'b0;
      req_r <= 1'b0;
      code_r <= 5'h00;
      op_a_r <= '0;
      op_b_r <= '0;
    end else begin
      st_r <= st_nxt;
      stk_r <= stk_nxt;
      ent_r <= ent_nxt;
      ready_r <= ready_nxt;
      warn_r <= warn_nxt;
      req_r <= req_nxt;
      code_r <= code_nxt;
      op_a_r <= op_a_nxt;
      op_b_r <= op_b_nxt;
    end
  end

  // Display of X: engineering exponent, point moved by the remainder
  always_comb begin
    int e;
    int r;
    int a;
    e = int'(stk_r[0].exp);
    r = e % 3;
    if (r < 0) r = r + 3;
    e = e - r;
    a = (e < 0) ? -e : e;
    let_addr = 4'(`LET_BIAS);
    dsp_nxt = '0;
    dsp_nxt.left = st_r == ST_MANT || st_r == ST_EXP;
    dsp_nxt.chars = ent_r.chars;
    dsp_nxt.cnt = ent_r.cnt;
    if (dsp_nxt.left) begin
      dsp_nxt.sign = ent_r.mneg;
      dsp_nxt.exp_bcd = {ent_r.d1, ent_r.d0};
      dsp_nxt.exp_neg = ent_r.eneg;
    end else begin
      dsp_nxt.sign = stk_r[0].neg;
      dsp_nxt.mant = stk_r[0].mant;
      dsp_nxt.point = 2'(r + 1);
      dsp_nxt.exp_bcd = {4'((a / 10) % 10), 4'(a % 10)};
      dsp_nxt.exp_neg = e < 0;
      dsp_nxt.letter_on = a <= `LET_RANGE;
      if (a <= `LET_RANGE) let_addr = 4'(e / 3 + `LET_BIAS);
      if (stk_r[0].mant != 16'h0000) begin
        dsp_nxt.ovf = stk_r[0].exp > `EXP_MAX;
        dsp_nxt.unf = stk_r[0].exp < `EXP_MIN ||
          (stk_r[0].exp == `EXP_MIN && stk_r[0].mant == `MANT_ONE);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dsp_r <= '0;
    end else begin
      dsp_r <= dsp_nxt;
    end
  end

  exp_letter_rom u_letters (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .addr(let_addr),
    .data_r(disp_letter)
  );

  assign key_ready = ready_r;
  assign warn = warn_r;
  assign fn_req = req_r;
  assign fn_code = code_r;
  assign fn_op_a = op_a_r;
  assign fn_op_b = op_b_r;
  assign x_value = stk_r[0];
  assign disp_left_align = dsp_r.left;
  assign disp_chars = dsp_r.chars;
  assign disp_char_cnt = dsp_r.cnt;
  assign disp_sign = dsp_r.sign;
  assign disp_mant = dsp_r.mant;
  assign disp_point = dsp_r.point;
  assign disp_exp_bcd = dsp_r.exp_bcd;
  assign disp_exp_neg = dsp_r.exp_neg;
  assign disp_letter_on = dsp_r.letter_on;
  assign disp_overflow = dsp_r.ovf;
  assign disp_underflow = dsp_r.unf;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_busy_refuses_keys: assert property (st_r == ST_BUSY |-> !key_ready)
    else $error("key accepted while busy");
  a_func_runs_at_once: assert property (take && k_fn |=> fn_req && st_r == ST_BUSY)
    else $error("function key did not start");
  a_binary_pops_both: assert property (take && k_two |=>
    fn_op_a == $past(stk_r[1]) && stk_r[1] == $past(stk_r[2]))
    else $error("two-operand pop wrong");
  a_result_into_x: assert property (st_r == ST_BUSY && fn_done |=>
    x_value == $past(fn_result) && key_ready)
    else $error("result not written to X");
  a_digit_pushes: assert property (take && k_dig && st_r == ST_IDLE |=>
    stk_r[1] == $past(stk_r[0]) && st_r == ST_MANT)
    else $error("new entry did not push");
  a_enter_ends_entry: assert property (take && key_code == `KEY_ENTER && st_r == ST_MANT
    |=> st_r == ST_IDLE ##1 !disp_left_align)
    else $error("enter left entry open");
  a_roll_rotates: assert property (take && key_code == `KEY_ROLL && st_r == ST_IDLE |=>
    stk_r[4] == $past(stk_r[0]) && stk_r[0] == $past(stk_r[1]))
    else $error("roll rotation wrong");
  a_clear_pops: assert property (take && key_code == `KEY_CLEAR_X_POP && st_r == ST_IDLE
    |=> x_value == $past(stk_r[1]))
    else $error("clear did not pop");
  a_default_mantissa: assert property (take && key_code == `KEY_EXP_ENTRY && st_r == ST_IDLE
    |=> st_r == ST_EXP && ent_r.cnt == 4'd1 && ent_r.chars[3:0] == 4'h1)
    else $error("default mantissa missing");
  a_entry_length: assert property (ent_r.cnt <= `ENT_MAX)
    else $error("entry overran twelve");
  a_exp_two_digits: assert property (take && k_dig && st_r == ST_EXP |=>
    ent_r.d1 == $past(ent_r.d0) && ent_r.d0 == $past(key_code[3:0]))
    else $error("exponent digits not shifted");
  a_value_kept: assert property (st_r == ST_IDLE && !take && disp_overflow |=>
    $stable(x_value))
    else $error("overflow altered X");
  a_ovf_shown: assert property (stk_r[0].mant != 16'h0000 && stk_r[0].exp > `EXP_MAX
    && st_r == ST_IDLE |=> disp_overflow)
    else $error("overflow not flagged");

  c_two_operand: cover property (take && k_two ##[1:20] fn_done);
  c_exp_entry: cover property (st_r == ST_EXP && take && key_code == `KEY_ENTER);
  c_length_warn: cover property (warn && st_r == ST_MANT);
endmodule : rpn_stack_entry_unit

// ---- test/arith_model.sv ----
// Arithmetic unit stand-in that answers function requests after a random delay
`timescale 1ns/1ps
module arith_model
  import rpn_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request and answer
  input wire logic fn_req,
  input wire value_t ans,
  output logic fn_done,
  output value_t fn_result
);
  int wait_n = -1;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_n <= -1;
      fn_done <= 1'b0;
      fn_result <= '0;
    end else begin
      fn_done <= 1'b0;
      // Result lines keep changing so a stale value is never mistaken for one
      fn_result <= ~fn_result;
      if (fn_req) begin
        wait_n <= $urandom_range(3, 0);
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else if (wait_n == 0) begin
        wait_n <= -1;
        fn_done <= 1'b1;
        fn_result <= ans;
      end
    end
  end
endmodule : arith_model

// ---- test/tb_rpn_stack_entry_unit.sv ----
// Self-checking bench for the stack and entry unit
`timescale 1ns/1ps
`include "rpn_defines.svh"
module tb_rpn_stack_entry_unit
  import rpn_pkg::*;
;
  logic core_clk, sys_rst, key_valid, key_ready, warn, fn_req, fn_done;
  logic [4:0] key_code, fn_code;
  logic [47:0] disp_chars;
  logic disp_left_align, disp_sign, disp_exp_neg, disp_letter_on, disp_overflow;
  logic disp_underflow;
  logic [15:0] disp_mant;
  logic [1:0] disp_point;
  logic [7:0] disp_exp_bcd, disp_letter;
  logic [3:0] disp_char_cnt, d;
  value_t fn_op_a, fn_op_b, fn_result, x_value, ans;
  value_t st[$];
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int w;

  rpn_stack_entry_unit rpn_stack_entry_unit_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .key_valid(key_valid), .key_code(key_code),
    .key_ready(key_ready), .warn(warn), .fn_req(fn_req), .fn_code(fn_code),
    .fn_op_a(fn_op_a), .fn_op_b(fn_op_b), .fn_done(fn_done), .fn_result(fn_result),
    .x_value(x_value), .disp_left_align(disp_left_align), .disp_chars(disp_chars),
    .disp_char_cnt(disp_char_cnt),
    .disp_sign(disp_sign), .disp_mant(disp_mant), .disp_point(disp_point),
    .disp_exp_bcd(disp_exp_bcd), .disp_exp_neg(disp_exp_neg),
    .disp_letter_on(disp_letter_on), .disp_letter(disp_letter),
    .disp_overflow(disp_overflow), .disp_underflow(disp_underflow));

  arith_model arith_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .fn_req(fn_req),
    .ans(ans), .fn_done(fn_done), .fn_result(fn_result));

  function automatic value_t v(input logic n, input logic [15:0] m, input logic signed [9:0] e);
    v = '{n, m, e};
  endfunction : v

  task test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Model stack keeps five entries, front is X
  task push(input value_t x);
    st.push_front(x);
    st = st[0:4];
  endtask : push

  // Called just after a rising edge; returns at the edge that took the key
  task key(input logic [4:0] c);
    int n;
    n = 0;
    key_valid <= 1'b1;
    key_code <= c;
    @(negedge core_clk);
    while (key_ready !== 1'b1 && n < 50) begin
      n++;
      @(negedge core_clk);
    end
    if (n == 50) chk("key_wait", key_ready, 1'b1);
    @(posedge core_clk);
  endtask : key

  task keys(input logic [4:0] q[$]);
    @(posedge core_clk);
    foreach (q[i]) key(q[i]);
    key_valid <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : keys

  task run(input logic [4:0] c, input value_t r);
    int n;
    n = 0;
    ans <= r;
    // Request pulse lasts one cycle, so look right after the taking edge
    @(posedge core_clk);
    key(c);
    key_valid <= 1'b0;
    @(negedge core_clk);
    chk("fn_req", fn_req, 1'b1);
    chk("fn_code", fn_code, c);
    chk("op_a", fn_op_a, st[1]);
    chk("op_b", fn_op_b, st[0]);
    chk("ready", key_ready, 1'b0);
    while (key_ready !== 1'b1 && n < 30) begin
      n++;
      @(negedge core_clk);
    end
    chk("ready_back", key_ready, 1'b1);
    repeat (2) @(negedge core_clk);
    void'(st.pop_front());
    st[0] = r;
    chk("x", x_value, st[0]);
  endtask : run

  task do_reset;
    sys_rst <= 1'b1;
    st.delete();
    repeat (5) st.push_back('0);
    repeat (6) @(posedge core_clk);
    chk("rst_ready", key_ready, 1'b1);
    chk("rst_x", x_value, 27'h0);
    sys_rst <= 1'b0;
  endtask : do_reset

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      test_done;
    end
  end

  initial begin
    sys_rst = 1'b1;
    key_valid = 1'b0;
    key_code = 5'h00;
    ans = '0;
    void'($urandom(44472));
    do_reset;
    keys('{5'h01, 5'h02});
    chk("left", disp_left_align, 1'b1);
    keys('{`KEY_ENTER});
    push(v(0, 16'h1200, 1));
    chk("x", x_value, st[0]);
    chk("left", disp_left_align, 1'b0);
    chk("mant", disp_mant, 16'h1200);
    chk("point", disp_point, 2'd2);
    keys('{5'h03});
    push(v(0, 16'h3000, 0));
    run(`KEY_ADD, v(0, 16'h1500, 1));
    // Digits straight after a result must push it, no enter
    keys('{5'h02});
    push(v(0, 16'h2000, 0));
    run(`KEY_DIV, v(0, 16'h7500, 0));
    d = 4'($urandom_range(9, 1));
    keys('{5'(d), `KEY_ENTER});
    push(v(0, {d, 12'h000}, 0));
    chk("x", x_value, st[0]);
    keys('{`KEY_EXP_ENTRY, 5'h01, 5'h02, 5'h03});
    chk("exp_keyed", disp_exp_bcd, 8'h23);
    keys('{`KEY_ENTER});
    push(v(0, 16'h1000, 23));
    chk("x", x_value, st[0]);
    chk("exp", disp_exp_bcd, 8'h21);
    chk("letter_on", disp_letter_on, 1'b0);
    chk("point", disp_point, 2'd3);
    // Sign toggle after run must still act on the exponent
    keys('{`KEY_EXP_ENTRY, 5'h06, `KEY_SIGN_TOGGLE, `KEY_SIGN_TOGGLE, `KEY_RUN,
      `KEY_SIGN_TOGGLE, `KEY_ENTER});
    push(v(0, 16'h1000, -6));
    chk("x", x_value, st[0]);
    chk("exp_neg", disp_exp_neg, 1'b1);
    chk("exp", disp_exp_bcd, 8'h06);
    chk("letter_on", disp_letter_on, 1'b1);
    chk("letter", disp_letter, 8'h75);
    run(`KEY_ADD, v(0, 16'h1000, 100));
    chk("ovf", disp_overflow, 1'b1);
    run(`KEY_ADD, v(1, 16'h1000, -99));
    chk("unf", disp_underflow, 1'b1);
    chk("sign", disp_sign, 1'b1);
    chk("ovf", disp_overflow, 1'b0);
    @(posedge core_clk);
    repeat (13) key(5'h01);
    key_valid <= 1'b0;
    w = 0;
    repeat (3) begin
      @(negedge core_clk);
      w += int'(warn === 1'b1);
    end
    chk("warn", 32'(w), 32'd1);
    chk("cnt", disp_char_cnt, 4'd12);
    chk("chars_lo", disp_chars[31:0], 32'h11111111);
    chk("chars_hi", disp_chars[47:32], 16'h1111);
    keys('{`KEY_ENTER});
    push(v(0, 16'h1111, 11));
    chk("x", x_value, st[0]);
    @(posedge core_clk);
    do_reset;
    keys('{5'h01, `KEY_ENTER, 5'h02, `KEY_ENTER, 5'h03, `KEY_ENTER, 5'h04, `KEY_ENTER,
      5'h05, `KEY_ENTER});
    for (int k = 1; k <= 5; k++) push(v(0, {4'(k), 12'h000}, 0));
    repeat (5) begin
      keys('{`KEY_ROLL});
      st.push_back(st.pop_front());
      chk("roll_x", x_value, st[0]);
    end
    keys('{`KEY_CLEAR_X_POP});
    void'(st.pop_front());
    chk("clx_x", x_value, st[0]);
    test_done;
  end
endmodule : tb_rpn_stack_entry_unit
